// *** src/flash_cmd_pkg.sv ***
// Purpose: Constants shared by the flash command host and its bus cycle engine.
// Assumes: 16-bit data bus, 22-bit word address, 10 MHz system clock.
// Notes: Codes are the low command byte; upper bits are driven as zero.
package flash_cmd_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int BANK_LSB = 19;
   localparam int SECTOR_LSB = 12;
   localparam logic [11:0] UNLOCK_ADDR_A = 12'h555;
   localparam logic [11:0] UNLOCK_ADDR_B = 12'h2AA;
   localparam logic [11:0] QUERY_ADDR = 12'h055;
   localparam logic [7:0] CODE_UNLOCK_A = 8'hAA;
   localparam logic [7:0] CODE_UNLOCK_B = 8'h55;
   localparam logic [7:0] CODE_AUTOSEL = 8'h90;
   localparam logic [7:0] CODE_PROGRAM = 8'hA0;
   localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CODE_RESUME = 8'h30;
   localparam logic [7:0] CODE_SUSPEND = 8'hB0;
   localparam logic [7:0] CODE_RESET = 8'hF0;
   localparam logic [7:0] CODE_CFI = 8'h98;
   localparam logic [7:0] CODE_BYPASS = 8'h20;
   localparam logic [7:0] CODE_BYPASS_EXIT = 8'h00;
   localparam logic [11:0] AUTOSEL_MFR_OFS = 12'h000;
   localparam logic [11:0] AUTOSEL_DEV1_OFS = 12'h001;
   localparam logic [11:0] AUTOSEL_DEV2_OFS = 12'h00E;
   localparam logic [11:0] AUTOSEL_DEV3_OFS = 12'h00F;
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETUP_NS = 100;
   localparam int STROBE_NS = 200;
   localparam int HOLD_NS = 100;
   localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] SYNC_CYC = 4'h4;
   typedef enum logic [3:0] {
      OP_READ, OP_RESET, OP_AUTOSEL, OP_PROGRAM, OP_CHIP_ERASE, OP_SECTOR_ERASE,
      OP_SUSPEND, OP_RESUME, OP_CFI, OP_BYPASS_ENTRY, OP_BYPASS_PROGRAM,
      OP_BYPASS_ERASE, OP_BYPASS_EXIT
   } op_t;
endpackage

// *** src/flash_bus_cycle.sv ***
// Purpose: Runs one asynchronous write or read cycle on the flash pins.
// Assumes: One clock; the select and write strobe are driven together.
// Notes: Address settles before the strobes fall and stays until they rise.
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle
   import flash_cmd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic write_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic [DATA_W-1:0] dq_sync_i,
   output logic busy_o,
   output logic done_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic [ADDR_W-1:0] addr_pin_o,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_n_o,
   output logic chip_sel_n_o,
   output logic write_n_o,
   output logic read_n_o
);
   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} phase_t;
   typedef struct packed {
      phase_t ph;
      logic [3:0] cnt;
      logic wr;
      logic done;
      logic [DATA_W-1:0] rdata;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq;
      logic dq_oe_n;
      logic cs_n;
      logic we_n;
      logic oe_n;
   } cyc_t;
   cyc_t s, next_s;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      unique case (s.ph)
         PH_IDLE: begin
            if (start_i) begin
               next_s.ph = PH_SETUP;
               next_s.cnt = SETUP_CYC;
               next_s.wr = write_i;
               next_s.addr = addr_i;
               next_s.dq = wdata_i;
               next_s.dq_oe_n = ~write_i;
            end
         end
         PH_SETUP: begin
            next_s.cnt = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
               // Address is stable before both strobes fall, so it latches cleanly. [R18]
               next_s.ph = PH_STROBE;
               // Reads stay low until the pin synchroniser has caught up with the data. [R9]
               next_s.cnt = s.wr ? STROBE_CYC : STROBE_CYC + SYNC_CYC;
               next_s.cs_n = 1'b0;
               next_s.we_n = ~s.wr;
               next_s.oe_n = s.wr;
            end
         end
         PH_STROBE: begin
            next_s.cnt = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
               // Both strobes rise together with data still driven. [R19]
               next_s.ph = PH_HOLD;
               next_s.cnt = HOLD_CYC;
               next_s.cs_n = 1'b1;
               next_s.we_n = 1'b1;
               next_s.oe_n = 1'b1;
               next_s.rdata = dq_sync_i;
            end
         end
         PH_HOLD: begin
            next_s.cnt = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
               next_s.ph = PH_IDLE;
               next_s.dq_oe_n = 1'b1;
               next_s.done = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '{ph: PH_IDLE, cnt: 4'h0, wr: 1'b0, done: 1'b0, rdata: '0, addr: '0, dq: '0,
                dq_oe_n: 1'b1, cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   assign busy_o = (s.ph != PH_IDLE);
   assign done_o = s.done;
   assign rdata_o = s.rdata;
   assign addr_pin_o = s.addr;
   assign dq_o = s.dq;
   assign dq_oe_n_o = s.dq_oe_n;
   assign chip_sel_n_o = s.cs_n;
   assign write_n_o = s.we_n;
   assign read_n_o = s.oe_n;

   AST_STROBE_WIDTH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $fell(chip_sel_n_o) |-> !chip_sel_n_o [*2]) else $error("Strobe shorter than two cycles."); // [R18]
   AST_DATA_HELD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      ($rose(write_n_o) && !dq_oe_n_o) |-> ($stable(dq_o) && !dq_oe_n_o))
      else $error("Write data moved at strobe rise."); // [R19]
endmodule
`default_nettype wire

// *** src/flash_cmd_host.sv ***
// Purpose: Host controller that issues flash command sequences over the pins.
// Assumes: Caller holds op and operands stable while req_i is high and busy_o is low.
// Notes: Refuses commands the device would ignore.
// Operation
// R1: Suspend only while programming runs.
// R2: Device halts program within latency after suspend.
// R3: Suspend address bits are don't care.
// R4: Suspended reads valid outside suspended sector.
// R5: Program suspend allowed inside erase suspend; the host refuses any suspend while one is held.
// R6: Host uses entry/exit sequences for secured region; this host has no secured-region commands.
// R7: Autoselect allowed during suspend, returns to suspend.
// R8: Resume continues interrupted programming.
// R9: Status bits report resumed programming normally.
// R10: Further resumes ignored; resume address don't care.
// R11: Suspend may repeat after each resume.
// R12: Autoselect is 555/AA, 2AA/55, bank 555/90.
// R13: Program is AA, 55, A0, address/data.
// R14: Erase is six cycles ending 10 or 30.
// R15: Bypass entry 20; short program, erase, exit.
// R16: F0 reset, B0 suspend, 30 resume, 98 query.
// R17: Bank address comes from top bits.
// R18: Address latches at later falling strobe.
// R19: Data latches at earlier rising strobe.
// R20: Sector address is top bits to twelve.
// R21: Command cycles ignore high address and data.
// R22: Autoselect or timeout needs reset to leave.
// R23: Erase suspend only for sector erase.
// R24: Broken unlock sequence abandons partial command.
// R25: Suspend, resume, autoselect apply to one bank.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_host
   import flash_cmd_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic req_i,
   input wire op_t op_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] data_i,
   input wire logic prog_busy_i,
   input wire logic [DATA_W-1:0] dq_i,
   output logic busy_o,
   output logic done_o,
   output logic refused_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic prog_suspended_o,
   output logic [ADDR_W-1:0] addr_pin_o,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_n_o,
   output logic chip_sel_n_o,
   output logic write_n_o,
   output logic read_n_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} state_t;
   typedef struct packed {
      state_t st;
      op_t op;
      logic [2:0] idx;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic start;
      logic done;
      logic refused;
      logic busy;
      logic suspended;
      logic [ADDR_W-BANK_LSB-1:0] susp_bank;
      logic autosel;
      logic bypass;
      logic chip_erasing;
      logic [DATA_W-1:0] dq_m1;
      logic [DATA_W-1:0] dq_m2;
      logic [DATA_W-1:0] dq_m3;
      logic [DATA_W-1:0] dq_sync;
   } host_t;
   host_t s, next_s;

   logic cyc_busy;
   logic cyc_done;
   logic [DATA_W-1:0] cyc_rdata;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_data;
   logic cyc_write;

   // Command cycles carry only the low address, the bank bits where with_bank is set, and the data byte. [R21]
   function automatic logic [ADDR_W-1:0] cmd_addr(input logic [ADDR_W-1:0] base, input logic [11:0] low,
                                                  input logic with_bank);
      cmd_addr = {with_bank ? base[ADDR_W-1:BANK_LSB] : '0, 7'h00, low}; // [R17]
   endfunction

   function automatic logic [DATA_W-1:0] cmd_data(input logic [7:0] code);
      cmd_data = {8'h00, code};
   endfunction

   function automatic logic [2:0] seq_len(input op_t op);
      unique case (op)
         OP_READ, OP_RESET, OP_SUSPEND, OP_RESUME, OP_CFI: seq_len = 3'd1;
         OP_BYPASS_PROGRAM, OP_BYPASS_ERASE, OP_BYPASS_EXIT: seq_len = 3'd2;
         OP_AUTOSEL, OP_BYPASS_ENTRY: seq_len = 3'd3;
         OP_PROGRAM: seq_len = 3'd4;
         default: seq_len = 3'd6;
      endcase
   endfunction

   // Cycle table: each command except OP_READ, a single read cycle, is a fixed list of address/data writes. [R12] [R13] [R14] [R15] [R16]
   always_comb begin
      cyc_write = 1'b1;
      cyc_addr = cmd_addr(s.addr, UNLOCK_ADDR_A, 1'b0);
      cyc_data = cmd_data(CODE_UNLOCK_A);
      if (s.idx == 3'd1 && s.op != OP_BYPASS_PROGRAM && s.op != OP_BYPASS_ERASE && s.op != OP_BYPASS_EXIT) begin
         cyc_addr = cmd_addr(s.addr, UNLOCK_ADDR_B, 1'b0);
         cyc_data = cmd_data(CODE_UNLOCK_B);
      end
      unique case (s.op)
         OP_READ: begin
            cyc_write = 1'b0;
            cyc_addr = s.addr;
         end
         OP_RESET: cyc_data = cmd_data(CODE_RESET);
         OP_SUSPEND: begin
            cyc_addr = cmd_addr(s.addr, 12'h000, 1'b1); // [R3]
            cyc_data = cmd_data(CODE_SUSPEND);
         end
         OP_RESUME: begin
            cyc_addr = cmd_addr(s.addr, 12'h000, 1'b1); // [R10]
            cyc_data = cmd_data(CODE_RESUME);
         end
         OP_CFI: begin
            cyc_addr = cmd_addr(s.addr, QUERY_ADDR, 1'b0);
            cyc_data = cmd_data(CODE_CFI);
         end
         OP_AUTOSEL, OP_BYPASS_ENTRY: if (s.idx == 3'd2) begin
            cyc_addr = cmd_addr(s.addr, UNLOCK_ADDR_A, 1'b1); // [R25]
            cyc_data = cmd_data(s.op == OP_AUTOSEL ? CODE_AUTOSEL : CODE_BYPASS);
         end
         OP_PROGRAM: if (s.idx == 3'd2) begin
            cyc_data = cmd_data(CODE_PROGRAM);
         end else if (s.idx == 3'd3) begin
            cyc_addr = s.addr;
            cyc_data = s.data;
         end
         OP_BYPASS_PROGRAM: if (s.idx == 3'd0) begin
            cyc_data = cmd_data(CODE_PROGRAM);
         end else begin
            cyc_addr = s.addr;
            cyc_data = s.data;
         end
         OP_BYPASS_ERASE: cyc_data = cmd_data(s.idx == 3'd0 ? CODE_ERASE_SETUP : CODE_CHIP_ERASE);
         OP_BYPASS_EXIT: cyc_data = cmd_data(s.idx == 3'd0 ? CODE_AUTOSEL : CODE_BYPASS_EXIT);
         default: if (s.idx == 3'd2) begin
            cyc_data = cmd_data(CODE_ERASE_SETUP);
         end else if (s.idx == 3'd3) begin
            cyc_data = cmd_data(CODE_UNLOCK_A);
         end else if (s.idx == 3'd4) begin
            cyc_addr = cmd_addr(s.addr, UNLOCK_ADDR_B, 1'b0);
            cyc_data = cmd_data(CODE_UNLOCK_B);
         end else if (s.idx == 3'd5) begin
            if (s.op == OP_SECTOR_ERASE) begin
               cyc_addr = {s.addr[ADDR_W-1:SECTOR_LSB], 12'h000}; // [R20]
               cyc_data = cmd_data(CODE_SECTOR_ERASE);
            end else begin
               cyc_data = cmd_data(CODE_CHIP_ERASE);
            end
         end
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.start = 1'b0;
      next_s.done = 1'b0;
      next_s.refused = 1'b0;
      // Pin input passes three flops; the read value is taken from a fourth, which loads the third only when the second and third agree.
      next_s.dq_m1 = dq_i;
      next_s.dq_m2 = s.dq_m1;
      next_s.dq_m3 = s.dq_m2;
      if (s.dq_m2 == s.dq_m3) begin
         next_s.dq_sync = s.dq_m3;
      end
      unique case (s.st)
         ST_IDLE: begin
            if (req_i) begin
               next_s.op = op_i;
               next_s.addr = addr_i;
               next_s.data = data_i;
               next_s.idx = 3'd0;
               next_s.st = ST_ISSUE;
               next_s.busy = 1'b1;
               // Refuse what the device would ignore, so no partial sequence is left. [R1] [R5] [R10] [R23]
               if ((op_i == OP_SUSPEND && !(prog_busy_i && !s.suspended) && !s.chip_erasing) ||
                   (op_i == OP_SUSPEND && s.chip_erasing) ||
                   (op_i == OP_RESUME && !s.suspended) ||
                   (op_i == OP_RESUME && addr_i[ADDR_W-1:BANK_LSB] != s.susp_bank) ||
                   ((op_i == OP_BYPASS_PROGRAM || op_i == OP_BYPASS_ERASE || op_i == OP_BYPASS_EXIT) && !s.bypass) ||
                   (s.autosel && op_i != OP_RESET && op_i != OP_READ)) begin // [R22] [R24]
                  next_s.st = ST_IDLE;
                  next_s.busy = 1'b0;
                  next_s.refused = 1'b1;
               end else begin
                  next_s.start = 1'b1;
               end
            end
         end
         ST_ISSUE: begin
            next_s.st = ST_WAIT;
         end
         ST_WAIT: begin
            if (cyc_done) begin
               if (s.idx == seq_len(s.op) - 3'd1) begin
                  next_s.st = ST_IDLE;
                  next_s.busy = 1'b0;
                  next_s.done = 1'b1;
                  unique case (s.op)
                     OP_SUSPEND: begin
                        next_s.suspended = 1'b1; // [R2] [R4]
                        next_s.susp_bank = s.addr[ADDR_W-1:BANK_LSB];
                     end
                     OP_RESUME: next_s.suspended = 1'b0; // [R8] [R11]
                     OP_AUTOSEL: next_s.autosel = 1'b1; // [R7]
                     OP_RESET: next_s.autosel = 1'b0;
                     OP_BYPASS_ENTRY: next_s.bypass = 1'b1;
                     OP_BYPASS_EXIT: next_s.bypass = 1'b0;
                     OP_CHIP_ERASE, OP_BYPASS_ERASE: next_s.chip_erasing = 1'b1;
                     default: ;
                  endcase
               end else begin
                  next_s.idx = s.idx + 3'd1;
                  next_s.st = ST_ISSUE;
                  next_s.start = 1'b1;
               end
            end
         end
      endcase
      if (!prog_busy_i && !s.suspended) begin
         next_s.chip_erasing = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '{st: ST_IDLE, op: OP_READ, idx: 3'd0, addr: '0, data: '0, start: 1'b0, done: 1'b0,
                refused: 1'b0, busy: 1'b0, suspended: 1'b0, susp_bank: '0, autosel: 1'b0, bypass: 1'b0,
                chip_erasing: 1'b0, dq_m1: '0, dq_m2: '0, dq_m3: '0, dq_sync: '0};
      end else begin
         s <= next_s;
      end
   end

   flash_bus_cycle u_cycle (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(s.start),
      .write_i(cyc_write),
      .addr_i(cyc_addr),
      .wdata_i(cyc_data),
      .dq_sync_i(s.dq_sync),
      .busy_o(cyc_busy),
      .done_o(cyc_done),
      .rdata_o(cyc_rdata),
      .addr_pin_o(addr_pin_o),
      .dq_o(dq_o),
      .dq_oe_n_o(dq_oe_n_o),
      .chip_sel_n_o(chip_sel_n_o),
      .write_n_o(write_n_o),
      .read_n_o(read_n_o)
   );

   assign busy_o = s.busy;
   assign done_o = s.done;
   assign refused_o = s.refused;
   assign rdata_o = cyc_rdata;
   assign prog_suspended_o = s.suspended;

   sequence seq_resume_req;
      s.st == ST_IDLE && req_i && op_i == OP_RESUME && !s.suspended;
   endsequence
   AST_RESUME_IGNORED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      seq_resume_req |=> refused_o && !busy_o) else $error("Stray resume was issued."); // [R10]
   AST_SUSPEND_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (s.st == ST_IDLE && req_i && op_i == OP_SUSPEND && !prog_busy_i) |=> refused_o)
      else $error("Suspend sent with no programming."); // [R1]
   AST_SUSPEND_SETS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (done_o && s.op == OP_SUSPEND) |-> prog_suspended_o) else $error("Suspend not recorded."); // [R2]
   AST_RESUME_CLEARS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (done_o && s.op == OP_RESUME) |-> !prog_suspended_o) else $error("Resume not recorded."); // [R8]
   AST_AUTOSEL_KEEP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (done_o && s.op == OP_AUTOSEL) |-> prog_suspended_o == $past(prog_suspended_o))
      else $error("Autoselect changed suspend state."); // [R7]
   AST_START_ONE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s.start |=> !s.start ##[1:12] cyc_done) else $error("Bus cycle did not finish."); // [R13]
   AST_CMD_HIGH_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (!write_n_o && s.op != OP_PROGRAM && s.op != OP_BYPASS_PROGRAM) |-> dq_o[15:8] == 8'h00)
      else $error("Command byte has upper bits set."); // [R21]
   AST_SUSP_CODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (!write_n_o && s.op == OP_SUSPEND) |-> dq_o == 16'h00B0) else $error("Wrong suspend code."); // [R16]
endmodule
`default_nettype wire

// *** tb/flash_dev_model.sv ***
// Purpose: Behavioural flash device on the far side of the command host.
// Assumes: Cycles decode on strobe edges; the clock only times program and erase.
// Notes: Logs every write cycle; a suspend halts at once.
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model #(
   parameter int BUSY_CYC = 400,
   parameter logic [15:0] MFR_CODE = 16'h00C5,
   parameter logic [15:0] DEV_CODE = 16'h1D3B
) (
   input wire logic sys_clk_i,
   input wire logic [21:0] addr_i,
   input wire logic [15:0] dq_i,
   input wire logic dq_oe_n_i,
   input wire logic chip_sel_n_i,
   input wire logic write_n_i,
   input wire logic read_n_i,
   output logic [15:0] dq_o,
   output logic busy_o
);
   logic [21:0] log_addr[$];
   logic [15:0] log_data[$];
   logic [21:0] lat_addr = '0;
   logic [21:0] prog_addr = '1;
   logic [15:0] prog_word = '0;
   logic [15:0] last = '0;
   logic [15:0] rd;
   logic prog = 1'b0;
   logic susp = 1'b0;
   logic autosel = 1'b0;
   logic bypass = 1'b0;
   logic tog = 1'b0;
   int step = 0;
   int left = 0;
   wire logic strobe_n = chip_sel_n_i | write_n_i;
   wire logic reading = !chip_sel_n_i && !read_n_i;

   function automatic logic [15:0] rd_val(input logic [21:0] a);
      if (autosel && a[11:0] == 12'h000) return MFR_CODE;
      if (autosel && a[11:0] == 12'h001) return DEV_CODE;
      if (busy_o && a[21:12] == prog_addr[21:12]) return {8'h00, ~prog_word[7], tog, 6'h00};
      if (a == prog_addr) return prog_word;
      return a[15:0] ^ 16'hA5A5;
   endfunction

   task begin_busy();
      left = BUSY_CYC;
      prog = 1'b1;
      step = 0;
   endtask

   always_comb rd = rd_val(addr_i);
   // A released bus shows the inverse of the last word.
   assign dq_o = !dq_oe_n_i ? dq_i : (reading ? rd : ~last);
   assign busy_o = prog && !susp;

   always @(posedge read_n_i) begin
      last = rd;
      if (busy_o) tog = ~tog;
   end

   always @(negedge strobe_n) lat_addr = addr_i;

   always @(posedge sys_clk_i) begin
      if (busy_o) begin
         left = left - 1;
         if (left == 0) prog = 1'b0;
      end
   end

   always @(posedge strobe_n) begin : decode
      logic [7:0] c;
      logic [11:0] lo;
      c = dq_i[7:0];
      lo = lat_addr[11:0];
      log_addr.push_back(lat_addr);
      log_data.push_back(dq_i);
      case (step)
         1, 4: step = (lo == 12'h2AA && c == 8'h55) ? step + 1 : 0;
         2: begin
            step = (c == 8'hA0) ? 3 : (c == 8'h80) ? 6 : 0;
            if (c == 8'h90) autosel = 1'b1;
            if (c == 8'h20) bypass = 1'b1;
         end
         3: begin
            prog_addr = lat_addr;
            prog_word = dq_i;
            begin_busy();
         end
         5: begin
            step = 0;
            if (c == 8'h10 || c == 8'h30) begin_busy();
         end
         6: begin
            step = (lo == 12'h555 && c == 8'hAA) ? 4 : 0;
            if (bypass && c == 8'h10) begin_busy();
         end
         7: begin
            step = 0;
            if (c == 8'h00) bypass = 1'b0;
         end
         default: begin
            if (lo == 12'h555 && c == 8'hAA) step = 1;
            else if (c == 8'hF0) autosel = 1'b0;
            else if (c == 8'hB0 && prog) susp = 1'b1;
            else if (c == 8'h30 && susp) susp = 1'b0;
            else if (bypass) step = (c == 8'hA0) ? 3 : (c == 8'h80) ? 6 : (c == 8'h90) ? 7 : 0;
         end
      endcase
   end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the flash command host against a device model.
// Assumes: Device busy time is a few hundred clocks.
// Notes: Writes are judged from the model's log.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import flash_cmd_pkg::*;
;
   localparam logic [15:0] MFR = 16'h00C5;  // Arbitrary value.
   localparam logic [15:0] DEV = 16'h1D3B;  // Arbitrary value.
   localparam logic [21:0] TA = 22'h2A1234;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req = 1'b0;
   op_t op = OP_READ;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] data = '0;
   logic busy, done, refused, suspended, dq_oe_n, chip_sel_n, write_n, read_n, dev_busy;
   logic [DATA_W-1:0] rdata, dq_host, dq_dev, s1;
   logic [ADDR_W-1:0] addr_pin;
   int mismatches = 0;
   int checked = 0;
   int n0 = 0;

   always #50 sys_clk = ~sys_clk;

   flash_cmd_host dut_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .req_i(req), .op_i(op), .addr_i(addr),
      .data_i(data), .prog_busy_i(dev_busy), .dq_i(dq_dev), .busy_o(busy), .done_o(done), .refused_o(refused),
      .rdata_o(rdata), .prog_suspended_o(suspended), .addr_pin_o(addr_pin), .dq_o(dq_host),
      .dq_oe_n_o(dq_oe_n), .chip_sel_n_o(chip_sel_n), .write_n_o(write_n), .read_n_o(read_n));

   flash_dev_model #(.BUSY_CYC(400), .MFR_CODE(MFR), .DEV_CODE(DEV)) dev_u (.sys_clk_i(sys_clk),
      .addr_i(addr_pin), .dq_i(dq_host), .dq_oe_n_i(dq_oe_n), .chip_sel_n_i(chip_sel_n),
      .write_n_i(write_n), .read_n_i(read_n), .dq_o(dq_dev), .busy_o(dev_busy));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      if (mismatches == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Outputs are read at the falling edge, clear of the edge that launches them.
   task automatic run_op(input op_t o, input logic [21:0] a, input logic [15:0] d, input logic exp_ref);
      n0 = dev_u.log_addr.size();
      @(posedge sys_clk);
      req <= 1'b1;
      op <= o;
      addr <= a;
      data <= d;
      @(posedge sys_clk);
      req <= 1'b0;
      for (int i = 0; i < 300; i++) begin
         @(negedge sys_clk);
         if (done === 1'b1 || refused === 1'b1) break;
      end
      check("answer", done === 1'b1 || refused === 1'b1, 1'b1);
      check("refused", refused, exp_ref);
      if (exp_ref) check("quiet", dev_u.log_addr.size() - n0, 0);
   endtask

   task automatic cmd(input op_t o, input logic [21:0] a, input logic r);
      run_op(o, a, 16'h0, r);
   endtask

   task automatic chk_n(input int n);
      check("wr_count", dev_u.log_addr.size() - n0, n);
   endtask

   task automatic chk_w(input int i, input int lo, input int bank, input logic [15:0] d);
      logic [21:0] a;
      a = dev_u.log_addr[n0 + i];
      if (lo >= 0) check("wr_addr", a[11:0], lo[11:0]);
      if (bank >= 0) check("wr_bank", a[21:19], bank[2:0]);
      check("wr_data", dev_u.log_data[n0 + i], d);
   endtask

   task automatic chk_unlock(input int base);
      chk_w(base, 'h555, 0, 16'hAA);
      chk_w(base + 1, 'h2AA, 0, 16'h55);
   endtask

   task automatic chk_erase(input logic [15:0] last);
      chk_n(6);
      chk_unlock(0);
      chk_w(2, 'h555, 0, 16'h80);
      chk_unlock(3);
      chk_w(5, (last == 16'h10) ? 'h555 : -1, -1, last);
   endtask

   task automatic rd(input logic [21:0] a, input logic [15:0] e);
      cmd(OP_READ, a, 1'b0);
      chk_n(0);
      check("rdata", rdata, e);
   endtask

   task automatic wait_ready();
      for (int i = 0; i < 2000 && dev_busy !== 1'b0; i++) @(negedge sys_clk);
      check("dev_ready", dev_busy, 1'b0);
   endtask

   task automatic t_prog_suspend();
      run_op(OP_PROGRAM, TA, 16'hC3A5, 1'b0);
      chk_n(4);
      chk_unlock(0);
      chk_w(2, 'h555, 0, 16'hA0);
      check("prog_addr", dev_u.prog_addr, TA);
      check("prog_word", dev_u.prog_word, 16'hC3A5);
      cmd(OP_READ, TA, 1'b0);
      s1 = rdata;
      cmd(OP_READ, TA, 1'b0);
      check("poll_bit", rdata[7], 1'b0);
      check("toggle_bit", rdata[6] ^ s1[6], 1'b1);
      cmd(OP_SUSPEND, 22'h2ABCDE, 1'b0);
      chk_w(0, 'h000, 5, 16'hB0);
      check("suspended", suspended, 1'b1);
      check("halted", dev_busy, 1'b0);
      rd(22'h0C0456, 16'h0456 ^ 16'hA5A5);
      cmd(OP_SUSPEND, TA, 1'b1);
   endtask

   task automatic t_autosel();
      cmd(OP_AUTOSEL, TA, 1'b0);
      chk_n(3);
      chk_unlock(0);
      chk_w(2, 'h555, 5, 16'h90);
      rd({TA[21:12], 12'h000}, MFR);
      rd({TA[21:12], 12'h001}, DEV);
      cmd(OP_RESUME, TA, 1'b1);
      cmd(OP_RESET, 22'h0, 1'b0);
      chk_w(0, -1, -1, 16'hF0);
      check("still_susp", suspended, 1'b1);
      rd(22'h281010, 16'h1010 ^ 16'hA5A5);
   endtask

   task automatic t_resume();
      cmd(OP_RESUME, 22'h100000, 1'b1);
      cmd(OP_RESUME, 22'h2A0FFF, 1'b0);
      chk_w(0, 'h000, 5, 16'h30);
      check("resumed", suspended, 1'b0);
      check("dev_prog", dev_busy, 1'b1);
      cmd(OP_RESUME, TA, 1'b1);
      cmd(OP_SUSPEND, TA, 1'b0);
      check("susp_again", suspended, 1'b1);
      cmd(OP_RESUME, TA, 1'b0);
      check("resumed_again", suspended, 1'b0);
      wait_ready();
      rd(TA, 16'hC3A5);
      cmd(OP_SUSPEND, TA, 1'b1);
   endtask

   task automatic t_erase();
      cmd(OP_CHIP_ERASE, 22'h0, 1'b0);
      chk_erase(16'h10);
      cmd(OP_SUSPEND, 22'h0, 1'b1);
      wait_ready();
      cmd(OP_SECTOR_ERASE, 22'h1F3ABC, 1'b0);
      chk_erase(16'h30);
      check("sector", dev_u.log_addr[n0 + 5][21:12], 10'h1F3);
      wait_ready();
   endtask

   task automatic t_bypass();
      run_op(OP_BYPASS_PROGRAM, 22'h18ABCD, 16'h1357, 1'b1);
      run_op(OP_BYPASS_ENTRY, 22'h180000, 16'h0000, 1'b0);
      chk_unlock(0);
      chk_w(2, 'h555, 3, 16'h20);
      run_op(OP_BYPASS_PROGRAM, 22'h18ABCD, 16'h1357, 1'b0);
      chk_n(2);
      chk_w(0, -1, -1, 16'hA0);
      chk_w(1, 'hBCD, 3, 16'h1357);
      wait_ready();
      rd(22'h18ABCD, 16'h1357);
      cmd(OP_BYPASS_ERASE, 22'h0, 1'b0);
      chk_w(0, -1, -1, 16'h80);
      chk_w(1, -1, -1, 16'h10);
      wait_ready();
      cmd(OP_BYPASS_EXIT, 22'h0, 1'b0);
      chk_w(0, -1, -1, 16'h90);
      chk_w(1, -1, -1, 16'h00);
      run_op(OP_BYPASS_PROGRAM, 22'h18ABCD, 16'h1357, 1'b1);
   endtask

   task automatic t_single();
      cmd(OP_CFI, 22'h2FFFFF, 1'b0);
      chk_w(0, 'h055, -1, 16'h98);
      cmd(OP_RESET, 22'h0, 1'b0);
      chk_w(0, -1, -1, 16'hF0);
   endtask

   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check("idle_pins", {chip_sel_n, write_n, read_n, dq_oe_n, busy, suspended}, 6'b111100);
      t_prog_suspend();
      t_autosel();
      t_resume();
      t_erase();
      t_bypass();
      t_single();
      final_report();
   end

   // The tests need well under half of this limit.
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      final_report();
   end
endmodule
`default_nettype wire
